// file: shared/aws_defines.svh
// Register offsets, field positions, reset values and codes for the attribute strobe block
`ifndef AWS_DEFINES_SVH
`define AWS_DEFINES_SVH

`define AWS_OFF_WIN0 4'h0
`define AWS_OFF_WIN1 4'h4
`define AWS_OFF_WIN2 4'h8
`define AWS_OFF_WIN3 4'hc
`define AWS_WIN_RESET 24'h000000
`define AWS_WIN_MASK 24'hffffbf
`define AWS_F_CADDR_HI 23
`define AWS_F_CADDR_LO 12
`define AWS_F_BCNT_HI 11
`define AWS_F_BCNT_LO 8
`define AWS_F_YEN 5
`define AWS_F_XEN 4
`define AWS_F_PEN 3
`define AWS_F_POL 2
`define AWS_F_AT_HI 1
`define AWS_F_AT_LO 0
`define AWS_AT_SRAM 2'h1
`define AWS_AT_DRAM 2'h2
`define AWS_RESP_OKAY 2'h0
`define AWS_RESP_SLVERR 2'h2

`endif

// file: shared/aws_pkg.sv
// Types shared by the attribute strobe block
package aws_pkg;
	typedef enum logic [1:0] {
		AWS_SPACE_P = 2'h0,
		AWS_SPACE_X = 2'h1,
		AWS_SPACE_Y = 2'h2,
		AWS_SPACE_NONE = 2'h3
	} aws_space_type;
	typedef enum logic [1:0] {
		AWS_W_IDLE = 2'h1,
		AWS_W_RESP = 2'h2
	} aws_wstate_type;
	typedef enum logic [1:0] {
		AWS_R_IDLE = 2'h1,
		AWS_R_DATA = 2'h2
	} aws_rstate_type;
endpackage

// file: design/aws_strobe_select.sv
// Four address attribute windows with strobe pins, AXI4-Lite register slave
//
// Behaviour
// - X-space enable set compares X data accesses; clear means no compare.
// - Program-space enable set compares program accesses; clear means no compare.
// - Polarity clear drives strobe active low.
// - Polarity set drives strobe active high.
// - Access type 01 is SRAM, 10 is DRAM, 00 and 11 reserved.
// - DRAM type makes strobe a row strobe, otherwise an attribute strobe.
// - External accesses matching no window use SRAM timing.
// - Reset loads type 00 and clears polarity and space enables.
// - Twelve compare bits match top of the 24-bit external address.
// - Bit count picks compared MSBs; zero matches all external; 13-15 reserved.
// - Y-space enable set compares Y data accesses; clear means no compare.
`timescale 1ns/1ps
`include "aws_defines.svh"

module aws_strobe_select (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_access_valid,
	input wire aws_pkg::aws_space_type ext_access_space,
	input wire logic [23:0] ext_address,
	input wire logic ext_address_internal,
	output logic [3:0] attribute_row_strobe,
	output logic [3:0] row_strobe_mode,
	output logic sram_timing,
	output logic dram_timing,
	output logic window_hit
);
	import aws_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decode helpers

	// Word address to window index; bit 2 set when address unmapped
	function automatic logic [2:0] win_decode(input logic [3:0] addr);
		unique case (addr)
			`AWS_OFF_WIN0: win_decode = 3'h0;
			`AWS_OFF_WIN1: win_decode = 3'h1;
			`AWS_OFF_WIN2: win_decode = 3'h2;
			`AWS_OFF_WIN3: win_decode = 3'h3;
			default: win_decode = 3'h4;
		endcase
	endfunction

	// Compare mask: top 'cnt' bits of the 12-bit field set
	function automatic logic [11:0] cmp_mask(input logic [3:0] cnt);
		logic [11:0] m;
		m = 12'h000;
		for (int i = 0; i < 12; i++) begin
			if (i >= 12 - int'(cnt)) begin
				m[i] = 1'b1;
			end
		end
		cmp_mask = m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Register bus slave

	logic [23:0] win_q [4];
	logic [23:0] win_d [4];
	aws_wstate_type wst_q, wst_d;
	aws_rstate_type rst_q, rst_d;
	logic [3:0] awaddr_q, awaddr_d;
	logic aw_got_q, aw_got_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic w_got_q, w_got_d;
	logic [1:0] bresp_q, bresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [2:0] widx;
	logic [2:0] ridx;
	logic [23:0] win_mask;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;

	assign widx = win_decode(awaddr_q);
	assign ridx = win_decode(s_axi_araddr);
	// Writable bits; reserved bit 6 always reads back as zero
	assign win_mask = `AWS_WIN_MASK;

	// Write path: collect address and data in either order, then respond
	always_comb begin
		wst_d = wst_q;
		awaddr_d = awaddr_q;
		aw_got_d = aw_got_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		w_got_d = w_got_q;
		bresp_d = bresp_q;
		for (int k = 0; k < 4; k++) begin
			win_d[k] = win_q[k];
		end
		unique case (wst_q)
			AWS_W_IDLE: begin
				if (s_axi_awvalid && !aw_got_q) begin
					awaddr_d = s_axi_awaddr;
					aw_got_d = 1'b1;
				end
				if (s_axi_wvalid && !w_got_q) begin
					wdata_d = s_axi_wdata;
					wstrb_d = s_axi_wstrb;
					w_got_d = 1'b1;
				end
				if (aw_got_q && w_got_q) begin
					if (widx[2]) begin
						bresp_d = `AWS_RESP_SLVERR;
					end else begin
						bresp_d = `AWS_RESP_OKAY;
						for (int b = 0; b < 3; b++) begin
							if (wstrb_q[b]) begin
								win_d[widx[1:0]][b*8 +: 8] = wdata_q[b*8 +: 8] & win_mask[b*8 +: 8];
							end
						end
					end
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					wst_d = AWS_W_RESP;
				end
			end
			AWS_W_RESP: begin
				if (s_axi_bready) begin
					wst_d = AWS_W_IDLE;
				end
			end
		endcase
		// Handshake outputs follow the next state so each leaves a flop
		awready_d = (wst_d == AWS_W_IDLE) && !aw_got_d;
		wready_d = (wst_d == AWS_W_IDLE) && !w_got_d;
		bvalid_d = (wst_d == AWS_W_RESP);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wst_q <= AWS_W_IDLE;
			awaddr_q <= 4'h0;
			aw_got_q <= 1'b0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			w_got_q <= 1'b0;
			bresp_q <= `AWS_RESP_OKAY;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			for (int k = 0; k < 4; k++) begin
				win_q[k] <= `AWS_WIN_RESET;
			end
		end else begin
			wst_q <= wst_d;
			awaddr_q <= awaddr_d;
			aw_got_q <= aw_got_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			w_got_q <= w_got_d;
			bresp_q <= bresp_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			for (int k = 0; k < 4; k++) begin
				win_q[k] <= win_d[k];
			end
		end
	end

	// Read path: one cycle to capture, then hold data until taken
	always_comb begin
		rst_d = rst_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		unique case (rst_q)
			AWS_R_IDLE: begin
				if (s_axi_arvalid) begin
					if (ridx[2]) begin
						rdata_d = 32'h00000000;
						rresp_d = `AWS_RESP_SLVERR;
					end else begin
						rdata_d = {8'h00, win_q[ridx[1:0]]};
						rresp_d = `AWS_RESP_OKAY;
					end
					rst_d = AWS_R_DATA;
				end
			end
			AWS_R_DATA: begin
				if (s_axi_rready) begin
					rst_d = AWS_R_IDLE;
				end
			end
		endcase
		// Read handshake outputs registered from the next state
		arready_d = (rst_d == AWS_R_IDLE);
		rvalid_d = (rst_d == AWS_R_DATA);
	end

	// Read state registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= AWS_R_IDLE;
			rdata_q <= 32'h00000000;
			rresp_q <= `AWS_RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end else begin
			rst_q <= rst_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
		end
	end

	// Ready and response outputs come from state flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Window match and strobe drive

	logic [3:0] hit;
	logic [3:0] strobe_d, strobe_q;
	logic [3:0] ras_d, ras_q;
	logic sram_d, sram_q, dram_d, dram_q, any_d, any_q;

	generate
		for (genvar g = 0; g < 4; g++) begin : g_win
			logic space_ok;
			logic addr_ok;
			logic [11:0] msk;
			assign space_ok = (ext_access_space == AWS_SPACE_X && win_q[g][`AWS_F_XEN])
				|| (ext_access_space == AWS_SPACE_P && win_q[g][`AWS_F_PEN])
				|| (ext_access_space == AWS_SPACE_Y && win_q[g][`AWS_F_YEN]);
			// count of bits, zero means whole external space
			assign msk = cmp_mask(win_q[g][`AWS_F_BCNT_HI:`AWS_F_BCNT_LO]);
			assign addr_ok = ((ext_address[23:12] ^ win_q[g][`AWS_F_CADDR_HI:`AWS_F_CADDR_LO]) & msk) == 12'h000;
			// only on enabled external matching access
			assign hit[g] = ext_access_valid && !ext_address_internal && space_ok && addr_ok;
		end
	endgenerate

	// Strobe levels, mode and timing selection
	always_comb begin
		sram_d = 1'b0;
		dram_d = 1'b0;
		any_d = |hit;
		for (int k = 0; k < 4; k++) begin
			strobe_d[k] = hit[k] ^ ~win_q[k][`AWS_F_POL];
			ras_d[k] = win_q[k][`AWS_F_AT_HI:`AWS_F_AT_LO] == `AWS_AT_DRAM;
		end
		// type code select, lowest window first
		for (int k = 3; k >= 0; k--) begin
			if (hit[k]) begin
				sram_d = win_q[k][`AWS_F_AT_HI:`AWS_F_AT_LO] == `AWS_AT_SRAM;
				dram_d = win_q[k][`AWS_F_AT_HI:`AWS_F_AT_LO] == `AWS_AT_DRAM;
			end
		end
		if (ext_access_valid && !ext_address_internal && !any_d) begin
			sram_d = 1'b1;
		end
	end

	// Pin registers; reset leaves strobes at the low-active idle level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strobe_q <= 4'hf;
			ras_q <= 4'h0;
			sram_q <= 1'b0;
			dram_q <= 1'b0;
			any_q <= 1'b0;
		end else begin
			strobe_q <= strobe_d;
			ras_q <= ras_d;
			sram_q <= sram_d;
			dram_q <= dram_d;
			any_q <= any_d;
		end
	end

	assign attribute_row_strobe = strobe_q;
	assign row_strobe_mode = ras_q;
	assign sram_timing = sram_q;
	assign dram_timing = dram_q;
	assign window_hit = any_q;
endmodule

// file: bench/aws_ext_mem.sv
// External memory model counting row opens
`timescale 1ns/1ps
module aws_ext_mem (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] row_strobe_mode,
	input wire logic dram_timing,
	output logic [7:0] n_row
);
	// row opened only on DRAM cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			n_row <= 8'h0;
		end else if (dram_timing && |row_strobe_mode) begin
			n_row <= n_row + 8'h1;
		end
	end
endmodule

// file: bench/aws_strobe_monitor.sv
// Port checks for the attribute strobe block
`timescale 1ns/1ps
module aws_strobe_monitor (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ext_access_valid,
	input wire aws_pkg::aws_space_type ext_access_space,
	input wire logic ext_address_internal,
	input wire logic [3:0] attribute_row_strobe,
	input wire logic [3:0] row_strobe_mode,
	input wire logic sram_timing,
	input wire logic dram_timing,
	input wire logic window_hit
);
	import aws_pkg::*;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	chk_rst_quiet: assert property ($rose(rst_n) |-> attribute_row_strobe == 4'hf && row_strobe_mode == 4'h0)
		else $error("strobe busy after reset");
	chk_int_quiet: assert property (ext_access_valid && ext_address_internal |=> !window_hit)
		else $error("internal access hit");
	chk_no_space: assert property (ext_access_space == AWS_SPACE_NONE |=> !window_hit)
		else $error("hit without space");
	chk_hit_cause: assert property (window_hit |-> $past(ext_access_valid) && !$past(ext_address_internal))
		else $error("hit without access");
	chk_idle_quiet: assert property (!ext_access_valid |=> !window_hit && !dram_timing)
		else $error("hit while idle");
	chk_one_timing: assert property (!(sram_timing && dram_timing))
		else $error("two timings");
	chk_dram_hit: assert property (dram_timing |-> window_hit && row_strobe_mode != 4'h0)
		else $error("dram timing without row window");
	chk_default_sram: assert property (ext_access_valid && !ext_address_internal |=> window_hit || sram_timing)
		else $error("default area not sram");
	cov_hit: cover property (window_hit);
	cov_dram: cover property (dram_timing);
	cov_int: cover property (ext_access_valid && ext_address_internal);
endmodule
bind aws_strobe_select aws_strobe_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .ext_access_valid(ext_access_valid),
	.ext_access_space(ext_access_space), .ext_address_internal(ext_address_internal),
	.attribute_row_strobe(attribute_row_strobe), .row_strobe_mode(row_strobe_mode), .sram_timing(sram_timing),
	.dram_timing(dram_timing), .window_hit(window_hit));

// file: bench/tb.sv
// Self-checking bench for the attribute strobe block
`timescale 1ns/1ps
module tb;
	import aws_pkg::*;
	typedef struct packed {logic [23:0] cfg; logic [1:0] sp; logic [23:0] ad; logic in; logic [10:0] ex;} aws_row_type;
	logic clk_sys, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ext_access_valid = 1'h0, ext_address_internal = 1'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, m;
	aws_space_type ext_access_space = AWS_SPACE_NONE;
	logic [23:0] ext_address = 24'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, sram_timing, dram_timing, window_hit;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr, rb;
	logic [3:0] attribute_row_strobe, row_strobe_mode;
	logic [7:0] n_row;
	int n_mismatch = 0, n_compared = 0;
	// Window 0 setting, access, expected {strobes, row modes, hit, sram, dram}
	aws_row_type rows [9] = '{
		'{24'ha00411, 2'h1, 24'ha12345, 1'h0, 11'h706},
		'{24'ha00411, 2'h1, 24'hb12345, 1'h0, 11'h782},
		'{24'ha00411, 2'h0, 24'ha12345, 1'h0, 11'h782},
		'{24'ha00410, 2'h1, 24'ha12345, 1'h0, 11'h704},
		'{24'ha0040e, 2'h0, 24'ha00000, 1'h0, 11'h78d},
		'{24'ha0040e, 2'h0, 24'ha00000, 1'h1, 11'h708},
		'{24'h000021, 2'h2, 24'h123456, 1'h0, 11'h706},
		'{24'habcc11, 2'h1, 24'habcfff, 1'h0, 11'h706},
		'{24'habcc11, 2'h1, 24'habdfff, 1'h0, 11'h782}};
	aws_strobe_select dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.ext_access_valid(ext_access_valid), .ext_access_space(ext_access_space), .ext_address(ext_address),
		.ext_address_internal(ext_address_internal), .attribute_row_strobe(attribute_row_strobe),
		.row_strobe_mode(row_strobe_mode), .sram_timing(sram_timing), .dram_timing(dram_timing),
		.window_hit(window_hit));
	aws_ext_mem mem (.clk_sys(clk_sys), .rst_n(rst_n), .row_strobe_mode(row_strobe_mode),
		.dram_timing(dram_timing), .n_row(n_row));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	// Register write, each channel released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic aw = 1'h1;
		logic w = 1'h1;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		while (aw || w) begin
			@(posedge clk_sys);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		rb = s_axi_bresp;
	endtask
	// Register read
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		rv = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	// One-cycle external access
	task automatic acc(input aws_row_type r);
		@(posedge clk_sys);
		ext_access_valid <= 1'h1;
		ext_access_space <= aws_space_type'(r.sp);
		ext_address <= r.ad;
		ext_address_internal <= r.in;
		@(posedge clk_sys);
		ext_access_valid <= 1'h0;
		#1;
	endtask
	task automatic rst();
		rst_n <= 1'h0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
	endtask
	task automatic close_out();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
	// Main sequence
	initial begin
		rst();
		for (int i = 1; i < 4; i++) wr(4'(4 * i), 32'h1);
		foreach (rows[i]) begin
			wr(4'h0, {8'h0, rows[i].cfg});
			acc(rows[i]);
			m = rows[i].in ? 32'h7fc : 32'h7ff;
			chk({21'h0, attribute_row_strobe, row_strobe_mode, window_hit, sram_timing, dram_timing} & m, rows[i].ex & m);
		end
		chk(32'(n_row), 32'h1);
		rd(4'h2);
		chk(32'(rr), 32'h2);
		// Unmapped write answers with an error response
		wr(4'h2, 32'h0);
		chk(32'(rb), 32'h2);
		wr(4'h4, 32'hffffffff);
		chk(32'(rb), 32'h0);
		rd(4'h4);
		chk(rv, 32'hffffbf);
		chk(32'(rr), 32'h0);
		rst();
		rd(4'h4);
		chk(rv, 32'h0);
		chk(32'(attribute_row_strobe), 32'hf);
		close_out();
	end
endmodule
